// ---- shared/dual_timer_params.svh ----
/*
  Constants for the dual timer/counter: register addresses, field positions,
  reset values and prescale counts. Assumes an 8-bit special-function-register bus.
*/
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_TIMER_MODE_SELECT 8'h89
`define ADDR_TIMER0_COUNT_LOW 8'h8a
`define ADDR_TIMER1_COUNT_LOW 8'h8b
`define ADDR_TIMER0_COUNT_HIGH 8'h8c
`define ADDR_TIMER1_COUNT_HIGH 8'h8d
`define ADDR_TIMER_AUX_CLOCK 8'ha3
`define ADDR_TIMER_AUX_PRESCALE 8'ha4
`define ADDR_TIMER_AUX_GATE 8'ha5
`define RESET_BYTE 8'h00
`define BIT_TF1 7
`define BIT_TR1 6
`define BIT_TF0 5
`define BIT_TR0 4
`define BIT_T1_GATE 7
`define BIT_T1_CT 6
`define BIT_T1_MODE_HI 5
`define BIT_T1_MODE_LO 4
`define BIT_T0_GATE 3
`define BIT_T0_CT 2
`define BIT_T0_MODE_HI 1
`define BIT_T0_MODE_LO 0
`define BIT_T1_FAST 3
`define BIT_T0_FAST 2
`define BIT_T1_CKOE 1
`define BIT_T0_CKOE 0
`define BIT_T0_XL 0
`define BIT_T1_G1 5
`define BIT_T0_G1 4
`define DIV12_LAST 8'd11
`define DIV48_LAST 8'd47
`define DIV192_LAST 8'd191
`define ZERO_BYTE 8'h00
`define ONES_BYTE 8'hff
`endif

// ---- shared/dual_timer_pkg.sv ----
/*
  Types for the dual timer/counter. Assumes the params header for numbers.
*/
`default_nettype none
package dual_timer_pkg;
    typedef enum logic [1:0] {
        MODE_PWM8,
        MODE_COUNT16,
        MODE_RELOAD8,
        MODE_SPLIT
    } timer_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfr_req_t;

    typedef struct packed {
        logic ext_irq_zero_active;
        logic ext_irq_one_active;
        logic timer_two_flag_active;
        logic timer_three_flag_active;
        logic serial_one_tx_flag_active;
        logic keyboard_irq_active;
    } gate_src_t;
endpackage : dual_timer_pkg
`default_nettype wire

// ---- core/dual_timer_counter.sv ----
/*
  Timer zero and timer one with 16-bit, 8-bit reload, split, stop and clock-out
  operation, reached over the special-function-register bus.
  Assumes the bus is on sys_clk; pins and the slow oscillator are asynchronous.
*/
// What this block does
// (RULE1) mode 1 counts 16 bits, same gating
// (RULE2) mode 2 low byte reloads from high byte
// (RULE3) timer one mode 3 holds its count
// (RULE4) timer zero mode 3 low byte own controls
// (RULE5) split high byte: internal clock, timer one controls
// (RULE6) clock-out enable forces reload and toggles pin
// (RULE7) clock-out rate is input over 2(256-reload)
// (RULE8) clock-out overflow still sets overflow flag
// (RULE9) software keeps interrupt off in clock-out
// (RULE10) timer one serves baud and clock-out together
// (RULE11) software loads bytes before setting run
// (RULE12) overflow flags set by hardware, cleared either
// (RULE13) run bit zero stops the timer
// (RULE14) two-bit gate select picks gate source
// (RULE15) two-bit mode field encodes four modes
// (RULE16) select bits pick eight or four clocks
// (RULE17) pin counts on high then low sample
// (RULE18) timer one clock: /12, pin, clock, /48
// (RULE19) timer zero clock: eight sources incl /192
// (RULE20) mode 0 rolls over and sets flag
// (RULE21) advance only when run and gate allow
// (RULE22) 16-bit wrap sets flag, no reload
`include "dual_timer_params.svh"
`default_nettype none
module dual_timer_counter
    import dual_timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire sfr_req_t sfr_req,
    input wire logic [7:0] sfr_wmask,
    input wire logic irq_ack_zero,
    input wire logic irq_ack_one,
    input wire logic timer_zero_pin,
    input wire logic timer_one_pin,
    input wire logic internal_low_speed_oscillator,
    input wire logic watchdog_prescaler_output,
    input wire gate_src_t gate_src,
    output logic [7:0] sfr_rdata,
    output logic timer_zero_clock_out_pin,
    output logic timer_one_clock_out_pin,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag,
    output logic timer_one_overflow_event
);
    logic [7:0] control_reg, mode_reg, aux_clock_reg, aux_prescale_reg, aux_gate_reg;
    logic [7:0] count_reg [4];
    logic [7:0] div12_reg, div48_reg, div192_reg;
    logic [2:0] pin0_sync_reg, pin1_sync_reg, lso_sync_reg, wdt_sync_reg;
    logic t1_ovf_reg;

    // async inputs: stage 0 feeds stage 1 only, stage 2 is the previous sample
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pin0_sync_reg <= 3'h0;
            pin1_sync_reg <= 3'h0;
            lso_sync_reg <= 3'h0;
            wdt_sync_reg <= 3'h0;
        end else begin
            pin0_sync_reg <= {pin0_sync_reg[1:0], timer_zero_pin};
            pin1_sync_reg <= {pin1_sync_reg[1:0], timer_one_pin};
            lso_sync_reg <= {lso_sync_reg[1:0], internal_low_speed_oscillator};
            wdt_sync_reg <= {wdt_sync_reg[1:0], watchdog_prescaler_output};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            div12_reg <= `ZERO_BYTE;
            div48_reg <= `ZERO_BYTE;
            div192_reg <= `ZERO_BYTE;
        end else begin
            div12_reg <= (div12_reg == `DIV12_LAST) ? `ZERO_BYTE : div12_reg + 8'h01;
            div48_reg <= (div48_reg == `DIV48_LAST) ? `ZERO_BYTE : div48_reg + 8'h01;
            div192_reg <= (div192_reg == `DIV192_LAST) ? `ZERO_BYTE : div192_reg + 8'h01;
        end
    end

    logic tick12, tick48, tick192;
    assign tick12 = (div12_reg == `DIV12_LAST);
    assign tick48 = (div48_reg == `DIV48_LAST);
    assign tick192 = (div192_reg == `DIV192_LAST);

    // pin edges sampled every sys_clk; falling sample pair counts
    logic pin0_fall, pin1_fall, lso_rise, wdt_rise;
    assign pin0_fall = pin0_sync_reg[2] & ~pin0_sync_reg[1]; // RULE17
    assign pin1_fall = pin1_sync_reg[2] & ~pin1_sync_reg[1]; // RULE17
    assign lso_rise = ~lso_sync_reg[2] & lso_sync_reg[1];
    assign wdt_rise = ~wdt_sync_reg[2] & wdt_sync_reg[1];

    timer_mode_t mode0, mode1;
    assign mode0 = timer_mode_t'(mode_reg[`BIT_T0_MODE_HI:`BIT_T0_MODE_LO]); // RULE15
    assign mode1 = timer_mode_t'(mode_reg[`BIT_T1_MODE_HI:`BIT_T1_MODE_LO]); // RULE15

    logic tick0, tick1;
    always_comb begin
        case ({aux_prescale_reg[`BIT_T0_XL], aux_clock_reg[`BIT_T0_FAST], mode_reg[`BIT_T0_CT]}) // RULE16 RULE19
            3'h0: tick0 = tick12;
            3'h1: tick0 = pin0_fall;
            3'h2: tick0 = 1'b1;
            3'h3: tick0 = lso_rise;
            3'h4: tick0 = tick48;
            3'h5: tick0 = wdt_rise;
            3'h6: tick0 = tick192;
            default: tick0 = t1_ovf_reg;
        endcase
        case ({aux_clock_reg[`BIT_T1_FAST], mode_reg[`BIT_T1_CT]}) // RULE16 RULE18
            2'h0: tick1 = tick12;
            2'h1: tick1 = pin1_fall;
            2'h2: tick1 = 1'b1;
            default: tick1 = tick48;
        endcase
    end

    logic gate0_ok, gate1_ok;
    always_comb begin
        case ({aux_gate_reg[`BIT_T0_G1], mode_reg[`BIT_T0_GATE]}) // RULE14
            2'h0: gate0_ok = 1'b1;
            2'h1: gate0_ok = gate_src.ext_irq_zero_active;
            2'h2: gate0_ok = gate_src.timer_two_flag_active;
            default: gate0_ok = gate_src.keyboard_irq_active;
        endcase
        case ({aux_gate_reg[`BIT_T1_G1], mode_reg[`BIT_T1_GATE]}) // RULE14
            2'h0: gate1_ok = 1'b1;
            2'h1: gate1_ok = gate_src.ext_irq_one_active;
            2'h2: gate1_ok = gate_src.timer_three_flag_active;
            default: gate1_ok = gate_src.serial_one_tx_flag_active;
        endcase
    end

    logic ckoe0, ckoe1, split;
    assign ckoe0 = aux_clock_reg[`BIT_T0_CKOE];
    assign ckoe1 = aux_clock_reg[`BIT_T1_CKOE];
    assign split = (mode0 == MODE_SPLIT) && !ckoe0;

    logic step0, step1, step_split_hi;
    assign step0 = control_reg[`BIT_TR0] & gate0_ok & tick0; // RULE13 RULE21
    // timer one stands still in mode 3 unless clock-out overrides the mode
    assign step1 = control_reg[`BIT_TR1] & gate1_ok & tick1 & (ckoe1 || mode1 != MODE_SPLIT); // RULE3 RULE21
    // split high byte: internal /12 or fast clock only, started by timer one run
    assign step_split_hi = split & control_reg[`BIT_TR1]
        & (aux_clock_reg[`BIT_T0_FAST] ? 1'b1 : tick12); // RULE5

    // per-timer count update; index 0 timer zero, 1 timer one
    logic [7:0] lo_next [2];
    logic [7:0] hi_next [2];
    logic ovf [2];
    logic ovf_hi_split;

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_timer
            logic step, ckoe;
            timer_mode_t md;
            assign step = (t == 0) ? step0 : step1;
            assign ckoe = (t == 0) ? ckoe0 : ckoe1;
            assign md = (t == 0) ? mode0 : mode1;
            always_comb begin
                lo_next[t] = count_reg[t];
                hi_next[t] = count_reg[t + 2];
                ovf[t] = 1'b0;
                if (step) begin
                    if (ckoe || md == MODE_RELOAD8) begin
                        ovf[t] = (count_reg[t] == `ONES_BYTE); // RULE2 RULE6 RULE8
                        lo_next[t] = ovf[t] ? count_reg[t + 2] : count_reg[t] + 8'h01; // RULE2 RULE6
                    end else if (md == MODE_SPLIT) begin
                        ovf[t] = (count_reg[t] == `ONES_BYTE); // RULE4
                        lo_next[t] = count_reg[t] + 8'h01; // RULE4
                    end else begin
                        // pwm and 16-bit both roll over the full 16 bits
                        {hi_next[t], lo_next[t]} = {count_reg[t + 2], count_reg[t]} + 16'h0001; // RULE1 RULE20
                        ovf[t] = ({count_reg[t + 2], count_reg[t]} == 16'hffff); // RULE22 RULE20
                    end
                end
            end
        end
    endgenerate

    assign ovf_hi_split = step_split_hi && (count_reg[2] == `ONES_BYTE); // RULE5

    logic wr_ctl, wr_mode;
    logic [3:0] wr_cnt;
    assign wr_ctl = sfr_req.wr && sfr_req.addr == `ADDR_TIMER_CONTROL;
    assign wr_mode = sfr_req.wr && sfr_req.addr == `ADDR_TIMER_MODE_SELECT;
    assign wr_cnt[0] = sfr_req.wr && sfr_req.addr == `ADDR_TIMER0_COUNT_LOW;
    assign wr_cnt[1] = sfr_req.wr && sfr_req.addr == `ADDR_TIMER1_COUNT_LOW;
    assign wr_cnt[2] = sfr_req.wr && sfr_req.addr == `ADDR_TIMER0_COUNT_HIGH;
    assign wr_cnt[3] = sfr_req.wr && sfr_req.addr == `ADDR_TIMER1_COUNT_HIGH;

    // software write wins over a count step on the same byte
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                count_reg[i] <= `RESET_BYTE;
            end
        end else begin
            count_reg[0] <= wr_cnt[0] ? sfr_req.wdata : lo_next[0];
            count_reg[1] <= wr_cnt[1] ? sfr_req.wdata : lo_next[1];
            count_reg[2] <= wr_cnt[2] ? sfr_req.wdata : (step_split_hi ? count_reg[2] + 8'h01 : hi_next[0]);
            count_reg[3] <= wr_cnt[3] ? sfr_req.wdata : hi_next[1];
        end
    end

    logic set_tf0, set_tf1;
    assign set_tf0 = ovf[0]; // RULE12
    // split high byte takes over timer one's flag; timer one still pulses its event
    assign set_tf1 = split ? ovf_hi_split : ovf[1]; // RULE5 RULE12

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            control_reg <= `RESET_BYTE;
        end else begin
            if (wr_ctl) begin
                control_reg <= (control_reg & ~sfr_wmask) | (sfr_req.wdata & sfr_wmask);
            end
            // hardware set wins over any clear in the same cycle
            if (irq_ack_zero && !set_tf0) begin
                control_reg[`BIT_TF0] <= 1'b0; // RULE12
            end
            if (irq_ack_one && !set_tf1) begin
                control_reg[`BIT_TF1] <= 1'b0; // RULE12
            end
            if (set_tf0) begin
                control_reg[`BIT_TF0] <= 1'b1; // RULE12 RULE8
            end
            if (set_tf1) begin
                control_reg[`BIT_TF1] <= 1'b1; // RULE12 RULE8
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mode_reg <= `RESET_BYTE;
            aux_clock_reg <= `RESET_BYTE;
            aux_prescale_reg <= `RESET_BYTE;
            aux_gate_reg <= `RESET_BYTE;
        end else begin
            if (wr_mode) begin
                mode_reg <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == `ADDR_TIMER_AUX_CLOCK) begin
                aux_clock_reg <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == `ADDR_TIMER_AUX_PRESCALE) begin
                aux_prescale_reg <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == `ADDR_TIMER_AUX_GATE) begin
                aux_gate_reg <= sfr_req.wdata;
            end
        end
    end

    // clock-out toggles once per overflow, giving 2*(256-reload) input ticks per period
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            timer_zero_clock_out_pin <= 1'b0;
            timer_one_clock_out_pin <= 1'b0;
            t1_ovf_reg <= 1'b0;
            timer_one_overflow_event <= 1'b0;
        end else begin
            if (ckoe0 && ovf[0]) begin
                timer_zero_clock_out_pin <= ~timer_zero_clock_out_pin; // RULE6 RULE7
            end
            if (ckoe1 && ovf[1]) begin
                timer_one_clock_out_pin <= ~timer_one_clock_out_pin; // RULE6 RULE7
            end
            t1_ovf_reg <= ovf[1];
            // baud source sees the same overflow that drives clock-out
            timer_one_overflow_event <= ovf[1]; // RULE10
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sfr_rdata <= `RESET_BYTE;
            timer_zero_overflow_flag <= 1'b0;
            timer_one_overflow_flag <= 1'b0;
        end else begin
            timer_zero_overflow_flag <= control_reg[`BIT_TF0];
            timer_one_overflow_flag <= control_reg[`BIT_TF1];
            if (sfr_req.rd) begin
                case (sfr_req.addr)
                    `ADDR_TIMER_CONTROL: sfr_rdata <= control_reg;
                    `ADDR_TIMER_MODE_SELECT: sfr_rdata <= mode_reg;
                    `ADDR_TIMER0_COUNT_LOW: sfr_rdata <= count_reg[0];
                    `ADDR_TIMER1_COUNT_LOW: sfr_rdata <= count_reg[1];
                    `ADDR_TIMER0_COUNT_HIGH: sfr_rdata <= count_reg[2];
                    `ADDR_TIMER1_COUNT_HIGH: sfr_rdata <= count_reg[3];
                    `ADDR_TIMER_AUX_CLOCK: sfr_rdata <= aux_clock_reg;
                    `ADDR_TIMER_AUX_PRESCALE: sfr_rdata <= aux_prescale_reg;
                    `ADDR_TIMER_AUX_GATE: sfr_rdata <= aux_gate_reg;
                    default: sfr_rdata <= `RESET_BYTE;
                endcase
            end
        end
    end
endmodule : dual_timer_counter
`default_nettype wire

// ---- tb/dual_timer_monitor.sv ----
/*
  Port-level checker for the dual timer/counter.
  Assumes binding from the bench top; sees only the design's ports.
*/
`default_nettype none
module dual_timer_monitor
    import dual_timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire sfr_req_t sfr_req,
    input wire logic [7:0] sfr_wmask,
    input wire logic [7:0] sfr_rdata,
    input wire logic timer_zero_overflow_flag,
    input wire logic timer_one_overflow_flag,
    input wire logic timer_one_overflow_event,
    input wire logic timer_zero_clock_out_pin,
    input wire logic timer_one_clock_out_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence ctrl_set(int b);
        sfr_req.wr && sfr_req.addr == 8'h88 && sfr_wmask[b] && sfr_req.wdata[b];
    endsequence
    // storage-only places; count bytes move on their own
    sequence store_wr;
        sfr_req.wr && sfr_req.addr inside {8'h89, 8'ha3, 8'ha4, 8'ha5};
    endsequence
    sequence same_rd;
        sfr_req.rd && !sfr_req.wr && sfr_req.addr == $past(sfr_req.addr, 2);
    endsequence

    reset_clear_a: assert property (disable iff (1'b0) !nrst |=> sfr_rdata == 8'h00 && !timer_zero_overflow_flag
        && !timer_one_overflow_flag && !timer_one_overflow_event && !timer_zero_clock_out_pin && !timer_one_clock_out_pin)
        else $error("outputs not cleared by reset");
    sw_set_one_a: assert property (ctrl_set(7) |-> ##2 timer_one_overflow_flag)
        else $error("software set of timer one flag lost");
    sw_set_zero_a: assert property (ctrl_set(5) |-> ##2 timer_zero_overflow_flag)
        else $error("software set of timer zero flag lost");
    flag_mirror_a: assert property (sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'h88 |=>
        sfr_rdata[7] == timer_one_overflow_flag && sfr_rdata[5] == timer_zero_overflow_flag)
        else $error("control read disagrees with flag outputs");
    event_flag_a: assert property (timer_one_overflow_event |=> timer_one_overflow_flag)
        else $error("timer one overflow without flag");
    unmapped_read_a: assert property (sfr_req.rd && !(sfr_req.addr inside {[8'h88:8'h8d], [8'ha3:8'ha5]})
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    store_readback_a: assert property (store_wr ##2 same_rd |=> sfr_rdata == $past(sfr_req.wdata, 3))
        else $error("stored byte not read back");
endmodule : dual_timer_monitor
`default_nettype wire

// ---- tb/timer_pins_model.sv ----
/*
  Far-side pins: drives the event pin that feeds both timers, measures the timer one clock-out.
  Assumes outputs are registered on sys_clk.
*/
`default_nettype none
module timer_pins_model (
    input wire logic sys_clk,
    input wire logic clk_out_pin,
    input wire logic ovf_event,
    output logic event_pin,
    output int period,
    output int toggles,
    output int events
);
    timeunit 1ns;
    timeprecision 100ps;
    int since = 0;
    logic last_out = 1'b0;
    initial begin
        event_pin = 1'b1;
        period = 0;
        toggles = 0;
        events = 0;
    end
    always @(posedge sys_clk) begin
        since = since + 1;
        if (ovf_event) begin
            events = events + 1;
        end
        if (clk_out_pin !== last_out) begin
            toggles = toggles + 1;
            if (clk_out_pin) begin
                period = since;
                since = 0;
            end
        end
        last_out = clk_out_pin;
    end
    // each level held four clocks so the sync chain sees it
    task automatic falls(input int n);
        repeat (n) begin
            repeat (4) @(posedge sys_clk);
            #2 event_pin = 1'b0;
            repeat (4) @(posedge sys_clk);
            #2 event_pin = 1'b1;
        end
    endtask : falls
endmodule : timer_pins_model
`default_nettype wire

// ---- tb/dual_timer_counter_modes_tb_top.sv ----
/*
  Self-checking bench for the dual timer/counter with an integer model.
  Assumes the monitor and the pins model; one clock, synchronous reset.
*/
`default_nettype none
module dual_timer_counter_modes_tb_top
    import dual_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    sfr_req_t sfr_req = '0;
    logic [7:0] sfr_wmask = 8'hff;
    logic irq_ack_zero = 1'b0;
    logic irq_ack_one = 1'b0;
    logic low_osc = 1'b0;
    logic wd_ps = 1'b0;
    gate_src_t gate_src = '0;
    logic pin_zero, tco0, tco1, tf0_o, tf1_o, t1_ev;
    logic [7:0] sfr_rdata;
    int period, toggles, events;
    int fails = 0;
    int cmp_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    dual_timer_counter dual_timer_counter_i (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_wmask(sfr_wmask),
        .irq_ack_zero(irq_ack_zero), .irq_ack_one(irq_ack_one), .timer_zero_pin(pin_zero), .timer_one_pin(pin_zero),
        .internal_low_speed_oscillator(low_osc), .watchdog_prescaler_output(wd_ps), .gate_src(gate_src),
        .sfr_rdata(sfr_rdata), .timer_zero_clock_out_pin(tco0), .timer_one_clock_out_pin(tco1),
        .timer_zero_overflow_flag(tf0_o), .timer_one_overflow_flag(tf1_o), .timer_one_overflow_event(t1_ev));
    timer_pins_model timer_pins_model_i (.sys_clk(sys_clk), .clk_out_pin(tco1), .ovf_event(t1_ev),
        .event_pin(pin_zero), .period(period), .toggles(toggles), .events(events));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // an idle cycle after each access keeps strobes from being rewritten in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
        sfr_req.addr = a;
        sfr_req.wdata = d;
        sfr_wmask = m;
        sfr_req.wr = 1'b1;
        @(posedge sys_clk);
        #2 sfr_req.wr = 1'b0;
        @(posedge sys_clk);
        #2;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req.addr = a;
        sfr_req.rd = 1'b1;
        @(posedge sys_clk);
        #2 sfr_req.rd = 1'b0;
        d = sfr_rdata;
        @(posedge sys_clk);
        #2;
    endtask : rd
    task automatic run_case(input int t, input int md);
        int lo, hi, n, steps;
        bit split;
        bit [1:0] f;
        logic [1:0] gsel;
        logic [3:0] srcs;
        logic [7:0] d, timer_mode_select;
        split = (md == 3 && t == 0);
        lo = $urandom % 256;
        hi = (md < 2) ? 255 : $urandom % 256;
        n = 2 + $urandom % 300;
        gsel = split ? 2'b00 : 2'($urandom);
        gate_src = 6'($urandom);
        srcs = t ? {gate_src.serial_one_tx_flag_active, gate_src.timer_three_flag_active, gate_src.ext_irq_one_active, 1'b1}
            : {gate_src.keyboard_irq_active, gate_src.timer_two_flag_active, gate_src.ext_irq_zero_active, 1'b1};
        steps = (srcs[gsel] && !(md == 3 && t == 1)) ? n : 0;
        timer_mode_select = split ? 8'h33 : t ? {gsel[0], 1'b0, 2'(md), 4'h0} : {4'h0, gsel[0], 1'b0, 2'(md)};
        wr(8'h88, 8'h00);
        wr(8'ha5, 8'(gsel[1]) << (4 + t));
        wr(8'h89, timer_mode_select);
        rd(8'h89, d);
        check(d, timer_mode_select);
        wr(8'h8a + 8'(t), 8'(lo));
        wr(8'h8c + 8'(t), 8'(hi));
        wr(8'h88, split ? 8'h50 : t ? 8'h40 : 8'h10);
        repeat (n - 2) @(posedge sys_clk);
        #2 wr(8'h88, 8'h00, 8'h50);
        f = 2'b00;
        for (int i = 0; i < steps; i++) begin
            lo = (lo + 1) % 256;
            if (md < 2 && lo == 0) hi = (hi + 1) % 256;
            if (md < 2 && lo == 0 && hi == 0) f[t] = 1'b1;
            if (md == 2 && lo == 0) begin
                lo = hi;
                f[t] = 1'b1;
            end
            if (split && lo == 0) f[0] = 1'b1;
            if (split) hi = (hi + 1) % 256;
            if (split && hi == 0) f[1] = 1'b1;
        end
        rd(8'h8a + 8'(t), d);
        check(d, 8'(lo));
        rd(8'h8c + 8'(t), d);
        check(d, 8'(hi));
        rd(8'h88, d);
        check(d, {f[1], 1'b0, f[0], 5'h00});
        check({6'h00, tf1_o, tf0_o}, {6'h00, f});
        irq_ack_zero = 1'b1;
        irq_ack_one = 1'b1;
        @(posedge sys_clk);
        #2 irq_ack_zero = 1'b0;
        irq_ack_one = 1'b0;
        @(posedge sys_clk);
        #2 rd(8'h88, d);
        check(d, 8'h00);
    endtask : run_case
    initial begin
        repeat (30000) @(posedge sys_clk);
        fails++;
        $display("MISMATCH t=%0t run did not finish", $time);
        give_verdict();
    end
    initial begin
        logic [7:0] d, r;
        int ev0, tg0;
        void'($urandom(59242));
        repeat (12) @(posedge sys_clk);
        #2 nrst = 1'b1;
        wr(8'h90, 8'hff);
        for (int a = 0; a < 10; a++) begin
            rd(a < 6 ? 8'h88 + 8'(a) : a < 9 ? 8'h9d + 8'(a) : 8'h90, d);
            check(d, 8'h00);
        end
        wr(8'ha3, 8'h0c);
        for (int k = 0; k < 4; k++) begin
            for (int md = 0; md < 4; md++) begin
                run_case(k % 2, md);
            end
        end
        wr(8'h88, 8'ha0, 8'ha0);
        rd(8'h88, d);
        check(d, 8'ha0);
        wr(8'h88, 8'h00);
        // gate select left over from the last random case could block timer one
        wr(8'ha5, 8'h00);
        wr(8'ha3, 8'h00);
        wr(8'h89, 8'h55);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h00);
        wr(8'h88, 8'h50);
        timer_pins_model_i.falls(5);
        repeat (8) @(posedge sys_clk);
        #2 wr(8'h88, 8'h00, 8'h50);
        rd(8'h8a, d);
        check(d, 8'h05);
        rd(8'h8b, d);
        check(d, 8'h05);
        // slow oscillator, then watchdog prescaler, as timer zero source
        for (int k = 0; k < 2; k++) begin
            wr(8'ha3, k ? 8'h00 : 8'h04);
            wr(8'ha4, 8'(k));
            wr(8'h8a, 8'h00);
            wr(8'h88, 8'h10);
            repeat (3) begin
                repeat (4) @(posedge sys_clk);
                #2 {low_osc, wd_ps} = 2'b11;
                repeat (4) @(posedge sys_clk);
                #2 {low_osc, wd_ps} = 2'b00;
            end
            repeat (4) @(posedge sys_clk);
            #2 wr(8'h88, 8'h00, 8'h50);
            rd(8'h8a, d);
            check(d, 8'h03);
        end
        wr(8'ha4, 8'h00);
        r = 8'hf0 + 8'($urandom % 15);
        wr(8'ha3, 8'h0f);
        wr(8'h89, 8'h10);
        wr(8'h8d, r);
        wr(8'h8b, r);
        wr(8'h8c, r);
        wr(8'h8a, r);
        ev0 = events;
        tg0 = toggles;
        wr(8'h88, 8'h50);
        repeat (200) @(posedge sys_clk);
        #2 check(8'(period), 8'(2 * (256 - int'(r))));
        check(8'(toggles - tg0), 8'(events - ev0));
        check({6'h00, tf1_o, tf0_o}, 8'h03);
        check({7'h00, tco0}, {7'h00, tco1});
        rd(8'h8d, d);
        check(d, r);
        give_verdict();
    end
endmodule : dual_timer_counter_modes_tb_top
bind dual_timer_counter dual_timer_monitor dual_timer_monitor_i (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req),
    .sfr_wmask(sfr_wmask), .sfr_rdata(sfr_rdata), .timer_zero_overflow_flag(timer_zero_overflow_flag),
    .timer_one_overflow_flag(timer_one_overflow_flag), .timer_one_overflow_event(timer_one_overflow_event),
    .timer_zero_clock_out_pin(timer_zero_clock_out_pin), .timer_one_clock_out_pin(timer_one_clock_out_pin));
`default_nettype wire
